/* File: verilog/pmes_pkg.sv */
package pmes_pkg;
  // Event numbers and unit masks
  localparam logic [7:0] EV_PORTS = 8'hB1;
  localparam logic [7:0] UM_P0 = 8'h01;
  localparam logic [7:0] UM_P1 = 8'h02;
  localparam logic [7:0] UM_P2 = 8'h04;
  localparam logic [7:0] UM_P3 = 8'h08;
  localparam logic [7:0] UM_P4 = 8'h10;
  localparam logic [7:0] UM_NO_P5 = 8'h1F;
  localparam logic [7:0] UM_P5 = 8'h20;
  localparam logic [7:0] UM_ALL = 8'h3F;
  localparam logic [7:0] UM_P015 = 8'h40;
  localparam logic [7:0] UM_P234 = 8'h80;
  localparam logic [7:0] EV_SQ_FULL = 8'hB2;
  localparam logic [7:0] UM_SQ_FULL = 8'h01;
  localparam logic [7:0] EV_RSP0 = 8'hB7;
  localparam logic [7:0] UM_RSP0 = 8'h01;
  localparam logic [7:0] EV_SNOOP = 8'hB8;
  localparam logic [7:0] UM_HIT = 8'h01;
  localparam logic [7:0] UM_HIT_EXCL = 8'h02;
  localparam logic [7:0] UM_HIT_MOD = 8'h04;
  localparam logic [7:0] EV_RSP1 = 8'hBB;
  localparam logic [7:0] UM_RSP1 = 8'h01;
  localparam logic [7:0] EV_RETIRED = 8'hC0;
  localparam logic [7:0] UM_RET_ANY = 8'h01;
  localparam logic [7:0] UM_RET_FP = 8'h02;
  // Register offsets
  localparam logic [7:0] OFF_EVTSEL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_FIXED_LO = 8'h08;
  localparam logic [7:0] OFF_FIXED_HI = 8'h0C;
  // Event select field positions
  localparam int EVT_LSB = 0;
  localparam int UMASK_LSB = 8;
  localparam int EDGE_BIT = 18;
  localparam int EN_BIT = 22;
  localparam int INV_BIT = 23;
  localparam int CMASK_LSB = 24;
  // Status field positions
  localparam int ST_INC_LSB = 0;
  localparam int ST_HIT_BIT = 8;
  localparam int ST_SUPP_BIT = 9;
  // Availability bit of the programmable retired event
  localparam int AVAIL_RET_BIT = 1;
  // Reset values
  localparam logic [31:0] EVTSEL_RST = 32'h0000_0000;
endpackage : pmes_pkg

/* File: verilog/pmes_qual.sv */
`timescale 1ns/1ps
module pmes_qual #(
  parameter int IW = 5
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  input wire logic act,
  input wire logic [IW-1:0] qty,
  input wire logic [7:0] cmask,
  input wire logic inv,
  input wire logic edge_en,
  output logic [IW-1:0] inc
);
  logic prev_ff;
  logic nxt_prev;
  logic cond;
  logic [7:0] q8;

  ////////////////////////////////////////////////////////////////////
  // Threshold, invert and edge qualification
  always_comb begin
    q8 = 8'(qty);
    cond = act && (cmask != 8'h00) && ((q8 >= cmask) ^ inv);
    nxt_prev = cond;
    if (!act) begin
      inc = '0;
    end else if (cmask == 8'h00) begin
      inc = qty;
    end else if (edge_en) begin
      inc = IW'(cond && !prev_ff);
    end else begin
      inc = IW'(cond);
    end
  end

  // Previous condition, for edge detection
  always_ff @(posedge clock) begin
    if (!nrst) begin
      prev_ff <= 1'b0;
    end else if (ce) begin
      prev_ff <= nxt_prev;
    end
  end
endmodule : pmes_qual

/* File: verilog/pmes_fix_ctr.sv */
`timescale 1ns/1ps
module pmes_fix_ctr #(
  parameter int RW = 4,
  parameter int FW = 48
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  input wire logic clr,
  input wire logic [RW-1:0] delta,
  output logic [FW-1:0] count
);
  logic [FW-1:0] count_ff;
  logic [FW-1:0] nxt_count;

  ////////////////////////////////////////////////////////////////////
  // Clear keeps this cycle's retirements so none are lost
  always_comb begin
    if (clr) begin
      nxt_count = FW'(delta);
    end else begin
      nxt_count = count_ff + FW'(delta);
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      count_ff <= '0;
    end else if (ce) begin
      count_ff <= nxt_count;
    end
  end

  assign count = count_ff;
endmodule : pmes_fix_ctr

/* File: verilog/pmes_exec_event_sel.sv */
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
module pmes_exec_event_sel #(
  parameter int PW = 2,
  parameter int IW = 5,
  parameter int RW = 4,
  parameter int FW = 48
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic [PW-1:0] port0_uops,
  input wire logic [PW-1:0] port1_uops,
  input wire logic [PW-1:0] port2_uops,
  input wire logic [PW-1:0] port3_uops,
  input wire logic [PW-1:0] port4_uops,
  input wire logic [PW-1:0] port5_uops,
  input wire logic super_queue_full,
  input wire logic offcore_rsp0,
  input wire logic offcore_rsp1,
  input wire logic snoop_hit,
  input wire logic snoop_hit_exclusive,
  input wire logic snoop_hit_modified,
  input wire logic [RW-1:0] retire_cnt,
  input wire logic [RW-1:0] retire_fault_cnt,
  input wire logic [RW-1:0] fp_mmx_retire_cnt,
  input wire logic [6:0] evt_avail,
  output logic [IW-1:0] prog_inc,
  output logic [FW-1:0] fixed_count
);
  logic [31:0] evtsel_ff;
  logic [31:0] nxt_evtsel;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [IW-1:0] inc_ff;
  logic [IW-1:0] nxt_inc;
  logic [7:0] ev;
  logic [7:0] um;
  logic [7:0] cm;
  logic inv;
  logic edg;
  logic en;
  logic [IW-1:0] e0;
  logic [IW-1:0] e1;
  logic [IW-1:0] e2;
  logic [IW-1:0] e3;
  logic [IW-1:0] e4;
  logic [IW-1:0] e5;
  logic [IW-1:0] e_no5;
  logic [IW-1:0] e_all;
  logic [RW-1:0] ret_net;
  logic supported;
  logic [IW-1:0] qty;
  logic hit;
  logic [IW-1:0] qinc;
  logic fix_clr;

  ////////////////////////////////////////////////////////////////////
  // Event select fields
  assign ev = evtsel_ff[pmes_pkg::EVT_LSB +: 8];
  assign um = evtsel_ff[pmes_pkg::UMASK_LSB +: 8];
  assign cm = evtsel_ff[pmes_pkg::CMASK_LSB +: 8];
  assign inv = evtsel_ff[pmes_pkg::INV_BIT];
  assign edg = evtsel_ff[pmes_pkg::EDGE_BIT];
  assign en = evtsel_ff[pmes_pkg::EN_BIT];

  // Per-port counts widened so sums never wrap
  assign e0 = IW'(port0_uops);
  assign e1 = IW'(port1_uops);
  assign e2 = IW'(port2_uops);
  assign e3 = IW'(port3_uops);
  assign e4 = IW'(port4_uops);
  assign e5 = IW'(port5_uops);
  assign e_no5 = e0 + e1 + e2 + e3 + e4;
  assign e_all = e_no5 + e5;

  // Faulting special instructions are taken out of the retired total
  assign ret_net = (retire_fault_cnt > retire_cnt) ? '0 :
                   RW'(retire_cnt - retire_fault_cnt);
  assign supported = !evt_avail[pmes_pkg::AVAIL_RET_BIT];

  ////////////////////////////////////////////////////////////////////
  // Event decode: one increment source per cycle
  always_comb begin
    qty = '0;
    hit = 1'b0;
    case (ev)
      pmes_pkg::EV_PORTS: begin
        hit = 1'b1;
        case (um)
          pmes_pkg::UM_P0: qty = e0;
          pmes_pkg::UM_P1: qty = e1;
          pmes_pkg::UM_P2: qty = e2;
          pmes_pkg::UM_P3: qty = e3;
          pmes_pkg::UM_P4: qty = e4;
          pmes_pkg::UM_NO_P5: qty = e_no5;
          pmes_pkg::UM_P5: qty = e5;
          pmes_pkg::UM_ALL: qty = e_all;
          pmes_pkg::UM_P015: qty = e0 + e1 + e5;
          pmes_pkg::UM_P234: qty = e2 + e3 + e4;
          default: hit = 1'b0;
        endcase
      end
      pmes_pkg::EV_SQ_FULL: begin
        hit = (um == pmes_pkg::UM_SQ_FULL);
        qty = IW'(super_queue_full && hit);
      end
      pmes_pkg::EV_RSP0: begin
        // Filter for this response is set up outside beforehand
        hit = (um == pmes_pkg::UM_RSP0);
        qty = IW'(offcore_rsp0 && hit);
      end
      pmes_pkg::EV_RSP1: begin
        hit = (um == pmes_pkg::UM_RSP1);
        qty = IW'(offcore_rsp1 && hit);
      end
      pmes_pkg::EV_SNOOP: begin
        hit = 1'b1;
        case (um)
          pmes_pkg::UM_HIT: qty = IW'(snoop_hit);
          pmes_pkg::UM_HIT_EXCL: qty = IW'(snoop_hit_exclusive);
          pmes_pkg::UM_HIT_MOD: qty = IW'(snoop_hit_modified);
          default: hit = 1'b0;
        endcase
      end
      pmes_pkg::EV_RETIRED: begin
        case (um)
          pmes_pkg::UM_RET_ANY: begin
            hit = supported;
            qty = supported ? IW'(ret_net) : '0;
          end
          pmes_pkg::UM_RET_FP: begin
            hit = 1'b1;
            qty = IW'(fp_mmx_retire_cnt);
          end
          default: hit = 1'b0;
        endcase
      end
      default: begin
        hit = 1'b0;
        qty = '0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Qualifier applies threshold, invert and edge
  pmes_qual #(
    .IW(IW)
  ) u_qual (
    .clock(clock),
    .nrst(nrst),
    .ce(ce),
    .act(en && hit),
    .qty(qty),
    .cmask(cm),
    .inv(inv),
    .edge_en(edg),
    .inc(qinc)
  );

  // Dedicated fixed counter of retired instructions
  assign fix_clr = wr && (addr == pmes_pkg::OFF_FIXED_LO);

  pmes_fix_ctr #(
    .RW(RW),
    .FW(FW)
  ) u_fix (
    .clock(clock),
    .nrst(nrst),
    .ce(ce),
    .clr(fix_clr),
    .delta(ret_net),
    .count(fixed_count)
  );

  ////////////////////////////////////////////////////////////////////
  // Register write and read next values
  always_comb begin
    nxt_evtsel = evtsel_ff;
    nxt_rdata = 32'h0000_0000;
    nxt_inc = qinc;
    if (wr && (addr == pmes_pkg::OFF_EVTSEL)) begin
      nxt_evtsel = wdata;
    end
    // Read data stand for one cycle only, zero otherwise
    if (rd) begin
      case (addr)
        pmes_pkg::OFF_EVTSEL: nxt_rdata = evtsel_ff;
        pmes_pkg::OFF_STATUS: begin
          nxt_rdata[pmes_pkg::ST_INC_LSB +: IW] = inc_ff;
          nxt_rdata[pmes_pkg::ST_HIT_BIT] = hit;
          nxt_rdata[pmes_pkg::ST_SUPP_BIT] = supported;
        end
        pmes_pkg::OFF_FIXED_LO: nxt_rdata = fixed_count[31:0];
        pmes_pkg::OFF_FIXED_HI: nxt_rdata = 32'(fixed_count[FW-1:32]);
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  // Registers; clock enable freezes everything
  always_ff @(posedge clock) begin
    if (!nrst) begin
      evtsel_ff <= pmes_pkg::EVTSEL_RST;
      rdata_ff <= 32'h0000_0000;
      inc_ff <= '0;
    end else if (ce) begin
      evtsel_ff <= nxt_evtsel;
      rdata_ff <= nxt_rdata;
      inc_ff <= nxt_inc;
    end
  end

  assign rdata = rdata_ff;
  assign prog_inc = inc_ff;

  ////////////////////////////////////////////////////////////////////
  // Checks
  logic wt;
  assign wt = ce && en && (cm == 8'h00);

  AST_PORT0: assert property (@(posedge clock) disable iff (!nrst)
    wt && ev == pmes_pkg::EV_PORTS && um == pmes_pkg::UM_P0
    |=> prog_inc == $past(e0))
    else $error("port 0 count wrong");

  AST_PORT1: assert property (@(posedge clock) disable iff (!nrst)
    wt && ev == pmes_pkg::EV_PORTS && um == pmes_pkg::UM_P1
    |=> prog_inc == $past(e1))
    else $error("port 1 count wrong");

  AST_PORT234: assert property (@(posedge clock) disable iff (!nrst)
    wt && ev == pmes_pkg::EV_PORTS && um == pmes_pkg::UM_P234
    |=> prog_inc == $past(e2) + $past(e3) + $past(e4))
    else $error("port 2-4 group count wrong");

  AST_NO_P5: assert property (@(posedge clock) disable iff (!nrst)
    wt && ev == pmes_pkg::EV_PORTS && um == pmes_pkg::UM_NO_P5
    |=> prog_inc == $past(e_all) - $past(e5))
    else $error("ports 0-4 count wrong");

  AST_ACTIVE: assert property (@(posedge clock) disable iff (!nrst)
    ce && en && cm == 8'h01 && !inv && !edg
    && ev == pmes_pkg::EV_PORTS && um == pmes_pkg::UM_ALL
    |=> prog_inc == IW'($past(e_all) != '0))
    else $error("active cycle count wrong");

  AST_STALL: assert property (@(posedge clock) disable iff (!nrst)
    ce && en && cm == 8'h01 && inv && !edg
    && ev == pmes_pkg::EV_PORTS && um == pmes_pkg::UM_P015
    |=> prog_inc == IW'($past(e0 + e1 + e5) == '0))
    else $error("stall cycle count wrong");

  AST_EDGE: assert property (@(posedge clock) disable iff (!nrst)
    ce && en && cm == 8'h01 && inv && edg
    && ev == pmes_pkg::EV_PORTS && um == pmes_pkg::UM_NO_P5
    && e_no5 == '0 ##1 ce && $stable(evtsel_ff) && e_no5 == '0
    |=> prog_inc == '0)
    else $error("edge counted inside a stall");

  AST_SQ: assert property (@(posedge clock) disable iff (!nrst)
    wt && ev == pmes_pkg::EV_SQ_FULL && um == pmes_pkg::UM_SQ_FULL
    |=> prog_inc == IW'($past(super_queue_full)))
    else $error("queue full count wrong");

  AST_UNDEF: assert property (@(posedge clock) disable iff (!nrst)
    ce && !hit |=> prog_inc == '0)
    else $error("undefined selection counted");

  AST_FIXED: assert property (@(posedge clock) disable iff (!nrst)
    ce && !fix_clr
    |=> fixed_count == $past(fixed_count) + FW'($past(ret_net)))
    else $error("fixed counter wrong");

  AST_FAULT: assert property (@(posedge clock) disable iff (!nrst)
    ce && retire_fault_cnt == retire_cnt && !fix_clr
    |=> fixed_count == $past(fixed_count))
    else $error("faulting instruction counted");

  AST_SUPP: assert property (@(posedge clock) disable iff (!nrst)
    ce && evt_avail[pmes_pkg::AVAIL_RET_BIT]
    && ev == pmes_pkg::EV_RETIRED && um == pmes_pkg::UM_RET_ANY
    |=> prog_inc == '0)
    else $error("unsupported retired event counted");

  AST_PORT2: assert property (@(posedge clock) disable iff (!nrst)
    wt && ev == pmes_pkg::EV_PORTS && um == pmes_pkg::UM_P2
    |=> prog_inc == IW'($past(port2_uops)))
    else $error("port 2 count wrong");

  AST_PORT3: assert property (@(posedge clock) disable iff (!nrst)
    wt && ev == pmes_pkg::EV_PORTS && um == pmes_pkg::UM_P3
    |=> prog_inc == IW'($past(port3_uops)))
    else $error("port 3 count wrong");

  AST_PORT4: assert property (@(posedge clock) disable iff (!nrst)
    wt && ev == pmes_pkg::EV_PORTS && um == pmes_pkg::UM_P4
    |=> prog_inc == IW'($past(port4_uops)))
    else $error("port 4 count wrong");

  AST_PORT5: assert property (@(posedge clock) disable iff (!nrst)
    wt && ev == pmes_pkg::EV_PORTS && um == pmes_pkg::UM_P5
    |=> prog_inc == IW'($past(port5_uops)))
    else $error("port 5 count wrong");

  AST_P015: assert property (@(posedge clock) disable iff (!nrst)
    wt && ev == pmes_pkg::EV_PORTS && um == pmes_pkg::UM_P015
    |=> prog_inc == IW'($past(port0_uops)) + IW'($past(port1_uops))
    + IW'($past(port5_uops)))
    else $error("port 0-1-5 group count wrong");

  AST_SNOOP: assert property (@(posedge clock) disable iff (!nrst)
    wt && ev == pmes_pkg::EV_SNOOP && um == pmes_pkg::UM_HIT_MOD
    |=> prog_inc == IW'($past(snoop_hit_modified)))
    else $error("modified snoop count wrong");

  AST_FP_MMX: assert property (@(posedge clock) disable iff (!nrst)
    wt && ev == pmes_pkg::EV_RETIRED && um == pmes_pkg::UM_RET_FP
    |=> prog_inc == IW'($past(fp_mmx_retire_cnt)))
    else $error("floating point retired count wrong");

  COV_WEIGHTED: cover property (@(posedge clock) disable iff (!nrst)
    wt && ev == pmes_pkg::EV_PORTS && e_all > IW'(1));
  COV_STALL_EDGE: cover property (@(posedge clock) disable iff (!nrst)
    ce && en && edg && inv && prog_inc == IW'(1));
  COV_RETIRED: cover property (@(posedge clock) disable iff (!nrst)
    ce && en && ev == pmes_pkg::EV_RETIRED && retire_fault_cnt != '0);
endmodule : pmes_exec_event_sel

/* File: tb/pmes_core_model.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// Counter side: sums every increment the selector hands over, except in a clear cycle
module pmes_core_model (
  input wire logic clock,
  input wire logic nrst,
  input wire logic clr,
  input wire logic [4:0] inc,
  output logic [15:0] total
);
  logic [15:0] total_ff;
  logic [15:0] nxt_total;

  // Clear wins so a measuring window starts from zero
  always_comb begin
    nxt_total = total_ff + 16'(inc);
    if (clr) begin
      nxt_total = 16'h0000;
    end
  end

  // Register only
  always_ff @(posedge clock) begin
    if (!nrst) begin
      total_ff <= 16'h0000;
    end else begin
      total_ff <= nxt_total;
    end
  end

  assign total = total_ff;
endmodule : pmes_core_model

/* File: tb/pmes_exec_event_sel_tb.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
module pmes_exec_event_sel_tb;
  // Ports are {p5..p0}, misc is {sq,rsp0,rsp1,hit,hitx,hit_modified}
  typedef struct packed {
    logic [7:0] ev;
    logic [7:0] um;
    logic [7:0] cm;
    logic inv;
    logic [11:0] pt;
    logic [5:0] ms;
    logic [11:0] rf;
    logic [4:0] ex;
  } pmes_row_s;

  logic clock, nrst, ce, wr, rd, clr;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, rv;
  logic [11:0] ports, rfp;
  logic [5:0] misc;
  logic [6:0] avail;
  logic [4:0] prog_inc;
  logic [47:0] fixed_count;
  logic [15:0] total;
  int fails, checks_done;

  // Port values 1,2,3,1,2,3 give group sums 9 (no p5), 12 (all), 6 (p015) and 6 (p234)
  pmes_row_s rows [28] = '{
    '{8'hB1, 8'h01, 8'h00, 1'h0, 12'hE79, 6'h00, 12'h000, 5'h01},
    '{8'hB1, 8'h02, 8'h00, 1'h0, 12'hE79, 6'h00, 12'h000, 5'h02},
    '{8'hB1, 8'h04, 8'h00, 1'h0, 12'hE79, 6'h00, 12'h000, 5'h03},
    '{8'hB1, 8'h08, 8'h00, 1'h0, 12'hE79, 6'h00, 12'h000, 5'h01},
    '{8'hB1, 8'h10, 8'h00, 1'h0, 12'hE79, 6'h00, 12'h000, 5'h02},
    '{8'hB1, 8'h1F, 8'h00, 1'h0, 12'hE79, 6'h00, 12'h000, 5'h09},
    '{8'hB1, 8'h20, 8'h00, 1'h0, 12'hE79, 6'h00, 12'h000, 5'h03},
    '{8'hB1, 8'h3F, 8'h00, 1'h0, 12'hE79, 6'h00, 12'h000, 5'h0C},
    '{8'hB1, 8'h3F, 8'h01, 1'h0, 12'hE79, 6'h00, 12'h000, 5'h01},
    '{8'hB1, 8'h40, 8'h00, 1'h0, 12'hE79, 6'h00, 12'h000, 5'h06},
    '{8'hB1, 8'h40, 8'h01, 1'h1, 12'h000, 6'h00, 12'h000, 5'h01},
    '{8'hB1, 8'h40, 8'h01, 1'h1, 12'hE79, 6'h00, 12'h000, 5'h00},
    '{8'hB1, 8'h80, 8'h00, 1'h0, 12'hE79, 6'h00, 12'h000, 5'h06},
    '{8'hB1, 8'h1F, 8'h09, 1'h0, 12'hE79, 6'h00, 12'h000, 5'h01},
    '{8'hB1, 8'h1F, 8'h0A, 1'h0, 12'hE79, 6'h00, 12'h000, 5'h00},
    '{8'hB2, 8'h01, 8'h00, 1'h0, 12'h000, 6'h20, 12'h000, 5'h01},
    '{8'hB2, 8'h01, 8'h00, 1'h0, 12'h000, 6'h1F, 12'h000, 5'h00},
    '{8'hB7, 8'h01, 8'h00, 1'h0, 12'h000, 6'h10, 12'h000, 5'h01},
    '{8'hBB, 8'h01, 8'h00, 1'h0, 12'h000, 6'h08, 12'h000, 5'h01},
    '{8'hB8, 8'h01, 8'h00, 1'h0, 12'h000, 6'h04, 12'h000, 5'h01},
    '{8'hB8, 8'h02, 8'h00, 1'h0, 12'h000, 6'h02, 12'h000, 5'h01},
    '{8'hB8, 8'h04, 8'h00, 1'h0, 12'h000, 6'h01, 12'h000, 5'h01},
    '{8'hB8, 8'h04, 8'h00, 1'h0, 12'h000, 6'h06, 12'h000, 5'h00},
    '{8'hC0, 8'h01, 8'h00, 1'h0, 12'h000, 6'h00, 12'h500, 5'h05},
    '{8'hC0, 8'h01, 8'h00, 1'h0, 12'h000, 6'h00, 12'h520, 5'h03},
    '{8'hC0, 8'h02, 8'h00, 1'h0, 12'h000, 6'h00, 12'h534, 5'h04},
    '{8'hB1, 8'h03, 8'h00, 1'h0, 12'hE79, 6'h00, 12'h000, 5'h00},
    '{8'hB3, 8'h01, 8'h00, 1'h0, 12'hE79, 6'h3F, 12'h000, 5'h00}
  };

  pmes_exec_event_sel u_dut (
    .clock(clock), .nrst(nrst), .ce(ce), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata),
    .port0_uops(ports[1:0]), .port1_uops(ports[3:2]),
    .port2_uops(ports[5:4]), .port3_uops(ports[7:6]),
    .port4_uops(ports[9:8]), .port5_uops(ports[11:10]),
    .super_queue_full(misc[5]), .offcore_rsp0(misc[4]),
    .offcore_rsp1(misc[3]), .snoop_hit(misc[2]),
    .snoop_hit_exclusive(misc[1]), .snoop_hit_modified(misc[0]),
    .retire_cnt(rfp[11:8]), .retire_fault_cnt(rfp[7:4]),
    .fp_mmx_retire_cnt(rfp[3:0]), .evt_avail(avail),
    .prog_inc(prog_inc), .fixed_count(fixed_count)
  );

  pmes_core_model u_model (
    .clock(clock), .nrst(nrst), .clr(clr), .inc(prog_inc), .total(total)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic summarize();
    if (fails == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  // One-cycle strobes; the slave never stalls
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    wr <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'h0;
  endtask : bus_wr

  // Read data only stands in the cycle after the strobe
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    rd <= 1'h1;
    addr <= a;
    @(posedge clock);
    rd <= 1'h0;
    #1 d = rdata;
  endtask : bus_rd

  // Stall pattern, LSB first: 4 stall cycles, 3 entries into a stall
  task automatic run_seq(input logic e, input logic [15:0] exp);
    logic [7:0] pat;
    pat = 8'h2D;
    ports <= 12'hE79;
    bus_wr(8'h00, {8'h01, 1'h1, 1'h1, 3'h0, e, 2'h0, 8'h1F, 8'hB1});
    @(posedge clock);
    clr <= 1'h1;
    for (int k = 0; k < 8; k++) begin
      @(posedge clock);
      clr <= 1'h0;
      ports <= pat[k] ? 12'h000 : 12'hE79;
    end
    @(posedge clock);
    ports <= 12'hE79;
    @(posedge clock);
    #1 check(32'(total), 32'(exp));
  endtask : run_seq

  ////////////////////////////////////////////////////////////////////////////
  // Free-running clock
  initial begin
    clock = 1'h0;
    forever #4 clock = ~clock;
  end

  // Hang guard ends the run as a failure
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    $display("Error %0t: timeout", $time);
    summarize();
  end

  initial begin
    nrst = 1'h0; ce = 1'h1; wr = 1'h0; rd = 1'h0; clr = 1'h0;
    addr = 8'h00; wdata = 32'h0; ports = 12'h0; misc = 6'h0;
    rfp = 12'h0; avail = 7'h00; fails = 0; checks_done = 0;
    repeat (16) @(posedge clock);
    nrst <= 1'h1;
    #1 check(32'(prog_inc), 32'h0);
    // Table walk: apply inputs, select, look one cycle later
    foreach (rows[i]) begin
      ports <= rows[i].pt;
      misc <= rows[i].ms;
      rfp <= rows[i].rf;
      bus_wr(8'h00, {rows[i].cm, rows[i].inv, 1'h1, 6'h00, rows[i].um,
                     rows[i].ev});
      @(posedge clock);
      #1 check(32'(prog_inc), 32'(rows[i].ex));
    end
    misc <= 6'h00;
    run_seq(1'h0, 16'h0004);
    run_seq(1'h1, 16'h0003);
    // Availability bit set blocks the programmable retired event
    bus_rd(8'h04, rv);
    check(32'(rv[9]), 32'h1);
    check(32'(rv[8]), 32'h1);
    avail <= 7'h02;
    rfp <= 12'h500;
    bus_wr(8'h00, 32'h0040_01C0);
    @(posedge clock);
    #1 check(32'(prog_inc), 32'h0);
    bus_rd(8'h04, rv);
    check(32'(rv[9]), 32'h0);
    check(32'(rv[8]), 32'h0);
    // Fixed counter: clear, 6 cycles of net 2, then frozen by ce
    rfp <= 12'h000;
    bus_wr(8'h08, 32'h0);
    @(posedge clock);
    rfp <= 12'h310;
    repeat (6) @(posedge clock);
    // Wholly faulting and over-faulting cycles add nothing
    rfp <= 12'h330;
    @(posedge clock);
    rfp <= 12'h130;
    @(posedge clock);
    ce <= 1'h0;
    rfp <= 12'h310;
    repeat (4) @(posedge clock);
    ce <= 1'h1;
    rfp <= 12'h000;
    #1 check(32'(fixed_count), 32'd12);
    bus_rd(8'h08, rv);
    check(rv, 32'h0000_000C);
    bus_rd(8'h0C, rv);
    check(rv, 32'h0);
    // Unmapped place reads back as zero
    bus_rd(8'h10, rv);
    check(rv, 32'h0);
    // Second reset mid-run
    nrst <= 1'h0;
    repeat (2) @(posedge clock);
    nrst <= 1'h1;
    #1 check(32'(fixed_count), 32'h0);
    bus_rd(8'h00, rv);
    check(rv, 32'h0);
    check(32'(prog_inc), 32'h0);
    summarize();
  end
endmodule : pmes_exec_event_sel_tb
